//--- rtl/cbcs_exec.sv
// executes block copies and condition-code instructions
// assumes on-chip memory answers a read with rdata in the same cycle as rd
`timescale 1ns/1ns

// Overview of operation
// - byte count: copy byte, bump pointers, decrement
// - byte count stops at zero; zero skips
// - word count: copy byte, bump pointers, decrement
// - word count stops at zero; zero skips
// - eight states plus four per byte
// - timings assume single-cycle on-chip memory
// - store to 24-bit displacement: ten bytes, flags kept
module cbcs_exec (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                srst,
    input  wire logic                ce,
    // command
    input  wire logic                cmd_valid,
    output logic                     cmd_ready,
    input  wire cbcs_pkg::cbcs_cmd_t cmd,
    // memory
    output cbcs_pkg::cbcs_mem_t      mem,
    input  wire logic [7:0]          mem_rdata,
    // results
    output logic                     done,
    output logic                     bad_length,
    output logic [7:0]               condition_code_register,
    output logic [15:0]              count_out,
    output logic [23:0]              src_out,
    output logic [23:0]              dst_out
);
    // ****************************************************************
    // state
    // ****************************************************************
    cbcs_pkg::cbcs_state_t state_r, state_nxt;
    cbcs_pkg::cbcs_op_t    op_r, op_nxt;
    cbcs_pkg::cbcs_mem_t   mem_r, mem_nxt;
    logic [7:0]            ccr_r, ccr_nxt;
    logic [15:0]           cnt_r, cnt_nxt;
    logic [23:0]           src_r, src_nxt;
    logic [23:0]           dst_r, dst_nxt;
    logic                  done_r, done_nxt;
    logic                  bad_r, bad_nxt;
    logic                  wait_load;
    logic [3:0]            wait_cycles;
    logic                  wait_expired;
    logic                  zero_cnt;

    cbcs_wait #(.WIDTH(4)) u_wait (
        .clk_sys (clk_sys),
        .srst    (srst),
        .ce      (ce),
        .load    (wait_load),
        .cycles  (wait_cycles),
        .expired (wait_expired)
    );

    // byte form only looks at the low count byte
    assign zero_cnt = (op_r == cbcs_pkg::CBCS_OP_COPY_B) ? (cnt_r[7:0] == 8'h00)
                                                         : (cnt_r == 16'h0000);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        state_nxt   = state_r;
        op_nxt      = op_r;
        mem_nxt     = '0;
        ccr_nxt     = ccr_r;
        cnt_nxt     = cnt_r;
        src_nxt     = src_r;
        dst_nxt     = dst_r;
        done_nxt    = 1'b0;
        bad_nxt     = bad_r;
        wait_load   = 1'b0;
        wait_cycles = 4'h0;
        case (state_r)
            cbcs_pkg::CBCS_IDLE:
            begin
                if (cmd_valid)
                begin
                    op_nxt  = cmd.op;
                    cnt_nxt = cmd.count;
                    src_nxt = cmd.src;
                    dst_nxt = cmd.dst;
                    bad_nxt = 1'b0;
                    case (cmd.op)
                        cbcs_pkg::CBCS_OP_COPY_B, cbcs_pkg::CBCS_OP_COPY_W:
                        begin
                            // fixed overhead, minus the cycle spent here and in done
                            wait_load   = 1'b1;
                            wait_cycles = 4'(cbcs_pkg::BASE_STATES - 2);
                            state_nxt   = cbcs_pkg::CBCS_SETUP;
                        end
                        cbcs_pkg::CBCS_OP_LDC:
                        begin
                            ccr_nxt   = cmd.imm;
                            done_nxt  = 1'b1;
                        end
                        cbcs_pkg::CBCS_OP_AND_CONDITION_CODES:
                        begin
                            ccr_nxt  = ccr_r & cmd.imm;
                            done_nxt = 1'b1;
                        end
                        cbcs_pkg::CBCS_OP_ORC:
                        begin
                            ccr_nxt  = ccr_r | cmd.imm;
                            done_nxt = 1'b1;
                        end
                        cbcs_pkg::CBCS_OP_XOR_CONDITION_CODES:
                        begin
                            ccr_nxt  = ccr_r ^ cmd.imm;
                            done_nxt = 1'b1;
                        end
                        cbcs_pkg::CBCS_OP_STC, cbcs_pkg::CBCS_OP_STC_D24:
                        begin
                            // flags untouched; the whole flag byte goes out
                            mem_nxt.wr    = 1'b1;
                            mem_nxt.addr  = cmd.dst;
                            mem_nxt.wdata = ccr_r;
                            // the long-displacement form is only legal at ten bytes
                            if (cmd.op == cbcs_pkg::CBCS_OP_STC_D24)
                                bad_nxt = (cmd.length != 4'(cbcs_pkg::STC_D24_BYTES));
                            done_nxt = 1'b1;
                        end
                        default:
                        begin
                            done_nxt = 1'b1;
                        end
                    endcase
                end
            end
            cbcs_pkg::CBCS_SETUP:
            begin
                if (wait_expired)
                begin
                    if (zero_cnt)
                        state_nxt = cbcs_pkg::CBCS_DONE;
                    else
                    begin
                        mem_nxt.rd   = 1'b1;
                        mem_nxt.addr = src_r;
                        state_nxt    = cbcs_pkg::CBCS_READ;
                    end
                end
            end
            cbcs_pkg::CBCS_READ:
            begin
                // data arrives this cycle from single-cycle memory
                mem_nxt.wr    = 1'b1;
                mem_nxt.addr  = dst_r;
                mem_nxt.wdata = mem_rdata;
                src_nxt       = src_r + 24'h000001;
                dst_nxt       = dst_r + 24'h000001;
                if (op_r == cbcs_pkg::CBCS_OP_COPY_B)
                    cnt_nxt = {cnt_r[15:8], cnt_r[7:0] - 8'h01};
                else
                    cnt_nxt = cnt_r - 16'h0001;
                // this read state is the first of the four per byte
                wait_load   = 1'b1;
                wait_cycles = 4'(cbcs_pkg::PER_BYTE_STATES - 1);
                state_nxt   = cbcs_pkg::CBCS_WRITE;
            end
            cbcs_pkg::CBCS_WRITE:
            begin
                if (wait_expired)
                begin
                    if (zero_cnt)
                        state_nxt = cbcs_pkg::CBCS_DONE;
                    else
                    begin
                        mem_nxt.rd   = 1'b1;
                        mem_nxt.addr = src_r;
                        state_nxt    = cbcs_pkg::CBCS_READ;
                    end
                end
            end
            cbcs_pkg::CBCS_DONE:
            begin
                done_nxt  = 1'b1;
                state_nxt = cbcs_pkg::CBCS_IDLE;
            end
            default:
            begin
                state_nxt = cbcs_pkg::CBCS_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_r <= cbcs_pkg::CBCS_IDLE;
            op_r    <= cbcs_pkg::CBCS_OP_NOP;
            mem_r   <= '0;
            ccr_r   <= cbcs_pkg::CCR_RESET;
            cnt_r   <= 16'h0000;
            src_r   <= 24'h000000;
            dst_r   <= 24'h000000;
            done_r  <= 1'b0;
            bad_r   <= 1'b0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            op_r    <= op_nxt;
            mem_r   <= mem_nxt;
            ccr_r   <= ccr_nxt;
            cnt_r   <= cnt_nxt;
            src_r   <= src_nxt;
            dst_r   <= dst_nxt;
            done_r  <= done_nxt;
            bad_r   <= bad_nxt;
        end
    end

    assign cmd_ready  = (state_r == cbcs_pkg::CBCS_IDLE);
    assign mem        = mem_r;
    assign done       = done_r;
    assign bad_length = bad_r;
    assign condition_code_register        = ccr_r;
    assign count_out  = cnt_r;
    assign src_out    = src_r;
    assign dst_out    = dst_r;
endmodule

//--- include/cbcs_pkg.sv
// package for the block-copy and condition-code execution unit
// assumes a single clock domain and a synchronous on-chip memory port
package cbcs_pkg;

    // ****************************************************************
    // timing, store length and flag reset value
    // ****************************************************************
    localparam int unsigned BASE_STATES     = 8;
    localparam int unsigned PER_BYTE_STATES = 4;
    localparam int unsigned STC_D24_BYTES   = 10;
    localparam logic [7:0]  CCR_RESET       = 8'h80;

    // ****************************************************************
    // operations
    // ****************************************************************
    typedef enum logic [3:0] {
        CBCS_OP_NOP      = 4'h0,
        CBCS_OP_COPY_B   = 4'h1,
        CBCS_OP_COPY_W   = 4'h2,
        CBCS_OP_LDC      = 4'h3,
        CBCS_OP_AND_CONDITION_CODES     = 4'h4,
        CBCS_OP_ORC      = 4'h5,
        CBCS_OP_XOR_CONDITION_CODES     = 4'h6,
        CBCS_OP_STC      = 4'h7,
        CBCS_OP_STC_D24  = 4'h8
    } cbcs_op_t;

    typedef struct packed {
        cbcs_op_t    op;
        logic [7:0]  imm;
        logic [15:0] count;
        logic [23:0] src;
        logic [23:0] dst;
        logic [3:0]  length;
    } cbcs_cmd_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [23:0] addr;
        logic [7:0]  wdata;
    } cbcs_mem_t;

    // states, gray from IDLE through SETUP, READ and WRITE to DONE
    typedef enum logic [2:0] {
        CBCS_IDLE  = 3'b000,
        CBCS_SETUP = 3'b001,
        CBCS_READ  = 3'b011,
        CBCS_WRITE = 3'b010,
        CBCS_DONE  = 3'b110
    } cbcs_state_t;
endpackage

//--- rtl/cbcs_wait.sv
// down-counter that pads a phase to a fixed number of states
// assumes load is a same-clock strobe
`timescale 1ns/1ns
module cbcs_wait #(
    parameter int unsigned WIDTH = 4
) (
    // clock
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic             ce,
    // control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] cycles,
    output logic                  expired
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (load)
            cnt_nxt = cycles;
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - WIDTH'(1);
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            cnt_r <= '0;
        else if (ce)
            cnt_r <= cnt_nxt;
    end

    assign expired = (cnt_r <= WIDTH'(1)) && !load;
endmodule

//--- testbench/cbcs_exec_props.sv
// checker for the execution unit, bound to its ports
// assumes ce is held high and the memory answers in the same cycle as a read
`timescale 1ns/1ns
module cbcs_exec_props (
    // clock and command
    input wire logic                clk_sys,
    input wire logic                srst,
    input wire logic                ce,
    input wire logic                cmd_valid,
    input wire logic                cmd_ready,
    input wire cbcs_pkg::cbcs_cmd_t cmd,
    // memory and results
    input wire cbcs_pkg::cbcs_mem_t mem,
    input wire logic [7:0]          mem_rdata,
    input wire logic                done,
    input wire logic                bad_length,
    input wire logic [7:0]          condition_code_register,
    input wire logic [15:0]         count_out,
    input wire logic [23:0]         src_out,
    input wire logic [23:0]         dst_out
);
    // ****************************************************************
    // copy timing helper
    // ****************************************************************
    wire         take = ce && cmd_valid && cmd_ready;
    wire         is_b = cmd.op == cbcs_pkg::CBCS_OP_COPY_B;
    wire         cp   = take && (is_b || cmd.op == cbcs_pkg::CBCS_OP_COPY_W);
    logic [19:0] cyc_r;
    logic [19:0] exp_r;
    logic        busy_r;
    always_ff @(posedge clk_sys)
    begin
        // the take edge counts as the first state
        cyc_r  <= cp ? 20'h1 : cyc_r + 20'h1;
        busy_r <= !srst && (cp || (busy_r && !done));
        if (cp)
            exp_r <= 20'h8 + 20'h4 * (is_b ? {12'h0, cmd.count[7:0]} : {4'h0, cmd.count});
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // ****************************************************************
    // properties
    // ****************************************************************
    a_copy_done_time: assert property (busy_r && done |-> cyc_r == exp_r)
        else $error("copy finished at the wrong state count");
    a_read_from_src: assert property (mem.rd |-> mem.addr == src_out)
        else $error("copy read not at source pointer");
    a_busy_not_ready: assert property (busy_r && !done |-> !cmd_ready)
        else $error("command accepted during a copy");
    a_write_to_dst: assert property (mem.rd |=> mem.wr && mem.wdata == $past(mem_rdata)
        && mem.addr == $past(dst_out))
        else $error("copy write wrong");
    a_pointers_step: assert property (mem.rd |-> ##2 src_out == $past(src_out, 2) + 24'h1
        && dst_out == $past(dst_out, 2) + 24'h1 && count_out == $past(count_out, 2) - 16'h1)
        else $error("pointer or count step wrong");
    a_zero_skip: assert property (cp && (is_b ? cmd.count[7:0] == 8'h0 : cmd.count == 16'h0)
        |-> ##1 (!mem.rd && !done) [*7] ##1 done)
        else $error("zero count copy not skipped");
    a_flags_kept: assert property (take && cmd.op inside {cbcs_pkg::CBCS_OP_NOP,
        cbcs_pkg::CBCS_OP_STC, cbcs_pkg::CBCS_OP_STC_D24} |-> ##1 condition_code_register == $past(condition_code_register))
        else $error("flags changed by store or nop");
    a_ccr_load: assert property (take && cmd.op == cbcs_pkg::CBCS_OP_LDC
        |-> ##1 condition_code_register == $past(cmd.imm))
        else $error("flag load wrong");
    a_ccr_and: assert property (take && cmd.op == cbcs_pkg::CBCS_OP_AND_CONDITION_CODES
        |-> ##1 condition_code_register == ($past(condition_code_register) & $past(cmd.imm)))
        else $error("flag and wrong");
    a_length_flag: assert property (take && cmd.op == cbcs_pkg::CBCS_OP_STC_D24
        |-> ##1 bad_length == ($past(cmd.length) != 4'ha))
        else $error("instruction length flag wrong");
endmodule
bind cbcs_exec cbcs_exec_props u_props (.clk_sys(clk_sys), .srst(srst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .mem(mem), .mem_rdata(mem_rdata),
    .done(done), .bad_length(bad_length), .condition_code_register(condition_code_register), .count_out(count_out),
    .src_out(src_out), .dst_out(dst_out));

//--- testbench/cbcs_mem_model.sv
// on-chip memory model answering the execution unit
// assumes addresses below 1024; byte i holds i xor 5a at start
`timescale 1ns/1ns
module cbcs_mem_model (
    // memory port
    input wire logic                clk_sys,
    input wire cbcs_pkg::cbcs_mem_t mem,
    output logic [7:0]              mem_rdata
);
    logic [7:0] ram [0:1023];
    logic [7:0] idle_r;
    initial
    begin
        for (int i = 0; i < 1024; i++)
            ram[i] = 8'(i) ^ 8'h5a;
        idle_r = 8'h00;
    end
    // undriven read data toggles so a late sample never matches by luck
    always @(posedge clk_sys)
    begin
        if (mem.wr)
            ram[mem.addr[9:0]] <= mem.wdata;
        idle_r <= ~idle_r;
    end
    // read data stands in the same cycle as the registered read strobe
    assign mem_rdata = mem.rd ? ram[mem.addr[9:0]] : idle_r;
endmodule

//--- testbench/cpu_block_copy_sysctl_exec_bench.sv
// self-checking bench for block copies and condition-code operations
// assumes the memory model and bound checker are compiled alongside
`timescale 1ns/1ns
`define CHECK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cpu_block_copy_sysctl_exec_bench;
    logic                clk_sys = 1'b0;
    logic                srst = 1'b1;
    logic                cmd_valid = 1'b0;
    logic                cmd_ready, done, bad_length;
    cbcs_pkg::cbcs_cmd_t cmd = '0;
    cbcs_pkg::cbcs_mem_t mem;
    cbcs_pkg::cbcs_mem_t wr_q[$];
    logic [7:0]          mem_rdata, condition_code_register;
    logic [15:0]         count_out;
    logic [23:0]         src_out, dst_out;
    int                  fails = 0;
    int                  compares = 0;
    int                  cycles;
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (mem.wr === 1'b1) wr_q.push_back(mem);
    cbcs_exec u_dut (.clk_sys(clk_sys), .srst(srst), .ce(1'b1), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .mem(mem), .mem_rdata(mem_rdata), .done(done),
        .bad_length(bad_length), .condition_code_register(condition_code_register), .count_out(count_out), .src_out(src_out),
        .dst_out(dst_out));
    cbcs_mem_model u_mem (.clk_sys(clk_sys), .mem(mem), .mem_rdata(mem_rdata));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic run(cbcs_pkg::cbcs_op_t op, logic [7:0] imm, logic [15:0] cnt,
        logic [23:0] dst, logic [3:0] len);
        @(negedge clk_sys);
        cmd = '{op, imm, cnt, 24'h000010, dst, len};
        cmd_valid = 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        // the take edge counts as the first state
        cycles = 1;
        while (done !== 1'b1 && cycles < 2000)
        begin
            @(negedge clk_sys);
            cycles++;
        end
    endtask
    task automatic copy(cbcs_pkg::cbcs_op_t op, logic [15:0] cnt, int n);
        wr_q.delete();
        run(op, 8'h00, cnt, 24'h000200, 4'h4);
        `CHECK(cycles, cbcs_pkg::BASE_STATES + cbcs_pkg::PER_BYTE_STATES * n)
        `CHECK(wr_q.size(), n)
        for (int i = 0; i < wr_q.size(); i++)
        begin
            `CHECK(wr_q[i].addr, 24'h000200 + 24'(i))
            `CHECK(wr_q[i].wdata, 8'(16 + i) ^ 8'h5a)
        end
        `CHECK(src_out, 24'h000010 + 24'(n))
        `CHECK(dst_out, 24'h000200 + 24'(n))
        `CHECK(count_out, cnt - 16'(n))
    endtask
    task automatic flag_op(cbcs_pkg::cbcs_op_t op, logic [7:0] imm, logic [3:0] len,
        logic [7:0] exp_ccr);
        run(op, imm, 16'h0000, 24'h000300, len);
        `CHECK(cycles, 1)
        `CHECK(condition_code_register, exp_ccr)
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_copy_byte;
        copy(cbcs_pkg::CBCS_OP_COPY_B, 16'h3400, 0);
        copy(cbcs_pkg::CBCS_OP_COPY_B, 16'h0001, 1);
        copy(cbcs_pkg::CBCS_OP_COPY_B, 16'habff, 255);
    endtask
    task automatic test_copy_word;
        copy(cbcs_pkg::CBCS_OP_COPY_W, 16'h0000, 0);
        // low byte zero must not stop the word form
        copy(cbcs_pkg::CBCS_OP_COPY_W, 16'h0100, 256);
    endtask
    task automatic test_flag_ops;
        flag_op(cbcs_pkg::CBCS_OP_LDC, 8'h3c, 4'h2, 8'h3c);
        flag_op(cbcs_pkg::CBCS_OP_AND_CONDITION_CODES, 8'h0f, 4'h2, 8'h0c);
        flag_op(cbcs_pkg::CBCS_OP_ORC, 8'hc0, 4'h2, 8'hcc);
        flag_op(cbcs_pkg::CBCS_OP_XOR_CONDITION_CODES, 8'hff, 4'h2, 8'h33);
        flag_op(cbcs_pkg::CBCS_OP_NOP, 8'hff, 4'h2, 8'h33);
        wr_q.delete();
        flag_op(cbcs_pkg::CBCS_OP_STC, 8'h00, 4'h4, 8'h33);
        // the store is logged at the edge that ends it
        @(negedge clk_sys);
        `CHECK(wr_q.size(), 1)
        `CHECK(wr_q[0].addr, 24'h000300)
        `CHECK(wr_q[0].wdata, 8'h33)
        flag_op(cbcs_pkg::CBCS_OP_STC_D24, 8'h00, 4'ha, 8'h33);
        `CHECK(bad_length, 1'b0)
        flag_op(cbcs_pkg::CBCS_OP_STC_D24, 8'h00, 4'h6, 8'h33);
        `CHECK(bad_length, 1'b1)
    endtask
    task automatic print_verdict;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        srst = 1'b0;
        `CHECK(condition_code_register, cbcs_pkg::CCR_RESET)
        test_copy_byte();
        test_copy_word();
        test_flag_ops();
        print_verdict();
    end
    // the copies need about 2100 cycles in all
    initial
    begin
        #(6000 * 50);
        fails++;
        print_verdict();
    end
endmodule
